/* File: pms_selector.sv */
/*
 * Parallel input message selector: debounces the discrete inputs and
 * the message control lines, scans them in round robin or priority
 * operation and issues display requests for programmed messages.
 * Assumes a message store that answers lkp_programmed for lkp_num in
 * the same cycle, and an AXI4-Lite master for configuration.
 */
`timescale 1ns/1ps
`include "pms_params.svh"

module pms_selector #(
  parameter int NUM_IN = 16,
  parameter logic [31:0] DEB_CYC_DEF = 32'(`PMS_DEB_CYC),
  parameter logic [31:0] DISP_CYC_DEF = 32'(`PMS_DISP_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_IN-1:0] par_in,
  input wire pms_pkg::pms_ctl_s ctl_in,
  output pms_pkg::pms_msg_t lkp_num,
  input wire logic lkp_programmed,
  output logic disp_req,
  output pms_pkg::pms_disp_s disp,
  output logic notice_req
);
  import pms_pkg::*;

  localparam int NL = NUM_IN + 4;
  localparam int HOLD = NUM_IN + 3;
  localparam logic [31:0] CTRL_RST = `PMS_CTRL_RESET;

  // Configuration
  logic prio_q;
  logic wide_q;
  logic [31:0] deb_cyc_q;
  logic [31:0] disp_cyc_q;

  // AXI slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;

  // Scanner state
  pms_state_e state_q;
  logic [4:0] idx_q;
  logic [31:0] timer_q;
  logic [NL-1:0] smp_q;
  logic [NL-1:0] deb_q;
  logic [31:0] deb_cnt_q [NL];
  logic [NL-1:0] seen_q;
  logic [NL-1:0] armed_q;
  logic st_q;
  logic chg_q;
  logic hold_ok_q;
  pms_msg_t cur_q;
  pms_msg_t lkp_num_q;
  logic disp_req_q;
  pms_disp_s disp_q;
  logic notice_q;

  // Input vector: data lines, then the four control lines
  wire [NL-1:0] raw = {ctl_in.data_hold, ctl_in.digit_sel2,
                       ctl_in.digit_sel1, ctl_in.msg_data, par_in};
  wire [4:0] lines = wide_q ? 5'(NL) : 5'(NUM_IN);
  wire last_line = (idx_q == lines - 5'd1);
  wire [4:0] idx_next = last_line ? 5'd0 : idx_q + 5'd1;
  wire hold_deb = deb_q[HOLD];
  wire [2:0] bank = {deb_q[NUM_IN+2], deb_q[NUM_IN+1], deb_q[NUM_IN]};
  wire [9:0] bank_add = wide_q ? 10'h000 :
                        10'(bank) * `PMS_BANK_STEP;
  wire [9:0] line_num = 10'(idx_q) + 10'd1;
  wire cur_st = deb_q[idx_q];
  wire [9:0] rr_num = (cur_st ? line_num : line_num + 10'(lines))
                      + bank_add;
  wire [9:0] def_num = wide_q ? `PMS_DEFAULT_MSG_WIDE : `PMS_DEFAULT_MSG;
  wire gate_ok = wide_q | hold_ok_q;

  // Lowest active input wins
  logic pri_any;
  logic [4:0] pri_idx;
  always_comb begin
    pri_any = 1'b0;
    pri_idx = 5'd0;
    for (int i = NL - 1; i >= 0; i--) begin
      if (deb_q[i] && (i < int'(lines))) begin
        pri_any = 1'b1;
        pri_idx = 5'(i);
      end
    end
  end
  wire [9:0] pri_num = pri_any ? 10'(pri_idx) + 10'd1 + bank_add
                               : def_num;
  wire is_def = (lkp_num_q == def_num);

  // Decisions taken in the check and show steps
  wire rr_hit = !prio_q && gate_ok && lkp_programmed
                && (armed_q[idx_q] || chg_q);
  wire pr_new = prio_q && gate_ok && (lkp_num_q != cur_q);
  wire pr_hit = pr_new && lkp_programmed;
  wire pr_note = pr_new && !lkp_programmed && is_def;
  wire in_check = (state_q == PMS_CHECK);
  wire show_done = (state_q == PMS_SHOW)
                   && (timer_q >= disp_cyc_q - 32'd1);
  wire advance = (in_check && !rr_hit) || show_done;

  // Per-line debounce, restarted on every change of the sample
  for (genvar g = 0; g < NL; g++) begin : g_deb
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        smp_q[g] <= 1'b0;
        deb_q[g] <= 1'b0;
        deb_cnt_q[g] <= 32'h0000_0000;
      end else begin
        smp_q[g] <= raw[g];
        if (raw[g] != smp_q[g]) begin
          deb_cnt_q[g] <= 32'h0000_0000;
        end else if (deb_cnt_q[g] < deb_cyc_q) begin
          deb_cnt_q[g] <= deb_cnt_q[g] + 32'd1;
        end else begin
          deb_q[g] <= smp_q[g];
        end
      end
    end
    p_deb: assert property (@(posedge aclk) disable iff (!aresetn)
      (deb_q[g] != $past(deb_q[g])) |->
        $past(deb_cnt_q[g]) >= $past(deb_cyc_q))
      else $error("debounce output changed early");
  end

  // Scan sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= PMS_LOOK;
      idx_q <= 5'd0;
      timer_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        PMS_LOOK: begin
          state_q <= PMS_CHECK;
        end
        PMS_CHECK: begin
          if (rr_hit) begin
            state_q <= PMS_SHOW;
            timer_q <= 32'h0000_0000;
          end else begin
            state_q <= PMS_LOOK;
            idx_q <= idx_next;
          end
        end
        PMS_SHOW: begin
          timer_q <= timer_q + 32'd1;
          if (show_done) begin
            state_q <= PMS_LOOK;
            idx_q <= idx_next;
          end
        end
        default: begin
          state_q <= PMS_LOOK;
        end
      endcase
    end
  end

  // Lookup, transition tracking and display requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lkp_num_q <= 10'h000;
      st_q <= 1'b0;
      chg_q <= 1'b0;
      seen_q <= '0;
      armed_q <= '0;
      hold_ok_q <= 1'b0;
      cur_q <= 10'h000;
      disp_req_q <= 1'b0;
      disp_q <= '0;
      notice_q <= 1'b0;
    end else begin
      disp_req_q <= 1'b0;
      notice_q <= 1'b0;
      if (!hold_deb) begin
        hold_ok_q <= 1'b0;
      end else if (advance && last_line) begin
        hold_ok_q <= 1'b1;
      end
      if (state_q == PMS_LOOK) begin
        lkp_num_q <= prio_q ? pri_num : rr_num;
        st_q <= cur_st;
        chg_q <= cur_st != seen_q[idx_q];
        seen_q[idx_q] <= cur_st;
      end
      if (in_check && !prio_q) begin
        armed_q[idx_q] <= rr_hit;
      end
      if (in_check && (rr_hit || pr_hit)) begin
        disp_req_q <= 1'b1;
        disp_q.num <= lkp_num_q;
        disp_q.first <= rr_hit && chg_q;
        cur_q <= lkp_num_q;
      end
      if (in_check && pr_note) begin
        notice_q <= 1'b1;
        cur_q <= lkp_num_q;
      end
    end
  end

  // AXI4-Lite write path
  wire aw_hs = s_axi_awvalid && awready_q;
  wire w_hs = s_axi_wvalid && wready_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire wr_hit = (awaddr_q == `PMS_ADDR_CTRL)
                || (awaddr_q == `PMS_ADDR_DEBOUNCE)
                || (awaddr_q == `PMS_ADDR_DISPLAY)
                || (awaddr_q == `PMS_ADDR_STATUS);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  wire [31:0] ctrl_rd = {30'h0000_0000, wide_q, prio_q};
  wire [31:0] ctrl_new = merge(ctrl_rd, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PMS_RESP_OKAY;
      prio_q <= CTRL_RST[`PMS_CTRL_PRIO_BIT];
      wide_q <= CTRL_RST[`PMS_CTRL_WIDE_BIT];
      deb_cyc_q <= DEB_CYC_DEF;
      disp_cyc_q <= DISP_CYC_DEF;
    end else begin
      if (aw_hs) begin
        awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        case (awaddr_q)
          `PMS_ADDR_CTRL: begin
            prio_q <= ctrl_new[`PMS_CTRL_PRIO_BIT];
            wide_q <= ctrl_new[`PMS_CTRL_WIDE_BIT];
          end
          `PMS_ADDR_DEBOUNCE: begin
            deb_cyc_q <= merge(deb_cyc_q, wdata_q, wstrb_q);
          end
          `PMS_ADDR_DISPLAY: begin
            disp_cyc_q <= merge(disp_cyc_q, wdata_q, wstrb_q);
          end
          default: begin
          end
        endcase
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path
  wire ar_hs = s_axi_arvalid && arready_q;
  wire [3:0] ar_word = {s_axi_araddr[3:2], 2'b00};
  wire [31:0] status_rd = {11'h000, hold_ok_q, 3'(state_q),
                           2'b00, idx_q, cur_q};
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (ar_word)
      `PMS_ADDR_CTRL: rd_mux = ctrl_rd;
      `PMS_ADDR_DEBOUNCE: rd_mux = deb_cyc_q;
      `PMS_ADDR_DISPLAY: rd_mux = disp_cyc_q;
      `PMS_ADDR_STATUS: rd_mux = status_rd;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PMS_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign lkp_num = lkp_num_q;
  assign disp_req = disp_req_q;
  assign disp = disp_q;
  assign notice_req = notice_q;

  // Checks
  property p_prog;
    @(posedge aclk) disable iff (!aresetn)
      disp_req_q |-> $past(lkp_programmed) && $past(in_check);
  endproperty
  a_prog: assert property (p_prog)
    else $error("display of unprogrammed message");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
      disp_req_q |-> $past(wide_q) || $past(hold_ok_q);
  endproperty
  a_gate: assert property (p_gate)
    else $error("display without data hold");

  property p_show;
    @(posedge aclk) disable iff (!aresetn)
      (disp_req_q && !$past(prio_q)) |-> (state_q == PMS_SHOW)
        && (timer_q == 32'h0000_0000);
  endproperty
  a_show: assert property (p_show)
    else $error("scan not paused for display");

  property p_resume;
    @(posedge aclk) disable iff (!aresetn)
      show_done |=> (state_q == PMS_LOOK)
        && (idx_q == $past(idx_next));
  endproperty
  a_resume: assert property (p_resume)
    else $error("scan did not resume at next input");

  property p_time;
    @(posedge aclk) disable iff (!aresetn)
      ($past(state_q) == PMS_SHOW) && (state_q == PMS_LOOK) |->
        $past(timer_q) + 32'd1 >= $past(disp_cyc_q);
  endproperty
  a_time: assert property (p_time)
    else $error("display time cut short");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
      (in_check && !rr_hit) |=> (idx_q == $past(idx_next))
        ##1 (state_q == PMS_CHECK);
  endproperty
  a_step: assert property (p_step)
    else $error("scan order broken");

  property p_note;
    @(posedge aclk) disable iff (!aresetn)
      notice_q |-> $past(is_def) && !$past(lkp_programmed)
        && $past(prio_q);
  endproperty
  a_note: assert property (p_note)
    else $error("notice without missing default");

  property p_first;
    @(posedge aclk) disable iff (!aresetn)
      (disp_req_q && disp_q.first) |-> $past(chg_q) && !$past(prio_q);
  endproperty
  a_first: assert property (p_first)
    else $error("first display without transition");

  property p_prio;
    @(posedge aclk) disable iff (!aresetn)
      ($past(prio_q) && disp_req_q) |-> (disp_q.num == cur_q)
        && (disp_q.num != $past(cur_q));
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority repeat or mismatch");

endmodule : pms_selector

/* File: pms_params.svh */
/*
 * Offsets, field positions, reset values and timing figures of the
 * parallel input message selector.
 * Assumes a 10 MHz system clock.
 */
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

`define PMS_CLK_HZ 10_000_000
`define PMS_ADDR_CTRL 4'h0
`define PMS_ADDR_DEBOUNCE 4'h4
`define PMS_ADDR_DISPLAY 4'h8
`define PMS_ADDR_STATUS 4'hC
`define PMS_CTRL_PRIO_BIT 0
`define PMS_CTRL_WIDE_BIT 1
`define PMS_CTRL_RESET 32'h0000_0000
`define PMS_DEB_TIME_MS 10
`define PMS_DISP_TIME_MS 2000
`define PMS_DEB_CYC (`PMS_DEB_TIME_MS * (`PMS_CLK_HZ / 1000))
`define PMS_DISP_CYC (`PMS_DISP_TIME_MS * (`PMS_CLK_HZ / 1000))
`define PMS_BANK_STEP 10'h064
`define PMS_DEFAULT_MSG 10'h011
`define PMS_DEFAULT_MSG_WIDE 10'h015
`define PMS_RESP_OKAY 2'h0
`define PMS_RESP_SLVERR 2'h2

`endif

/* File: pms_pkg.sv */
/*
 * Types of the parallel input message selector.
 * Assumes pms_params.svh is on the include path.
 */
package pms_pkg;

  typedef enum logic [2:0] {
    PMS_LOOK  = 3'b001,
    PMS_CHECK = 3'b010,
    PMS_SHOW  = 3'b100
  } pms_state_e;

  typedef logic [9:0] pms_msg_t;

  typedef struct packed {
    logic first;
    pms_msg_t num;
  } pms_disp_s;

  typedef struct packed {
    logic msg_data;
    logic digit_sel1;
    logic digit_sel2;
    logic data_hold;
  } pms_ctl_s;

endpackage : pms_pkg

/* File: pms_field.sv */
/*
 * Far side model: message store lookup and the field control lines.
 * Assumes the bench sets the programmed map and the line levels.
 */
`timescale 1ns/1ps

module pms_field (
  input wire logic [1023:0] prog_map,
  input wire pms_pkg::pms_msg_t lkp_num,
  output logic lkp_programmed,
  input wire logic hold_on,
  input wire logic [2:0] bank,
  output pms_pkg::pms_ctl_s ctl_in
);
  import pms_pkg::*;

  // Store answers in the same cycle
  assign lkp_programmed = prog_map[lkp_num];
  assign ctl_in.data_hold = hold_on;
  assign ctl_in.digit_sel2 = bank[2];
  assign ctl_in.digit_sel1 = bank[1];
  assign ctl_in.msg_data = bank[0];
endmodule : pms_field

/* File: tb_top.sv */
/*
 * Self-checking bench: register access, round robin, priority, wide mode.
 * Assumes short debounce and display counts set by parameter.
 */
`timescale 1ns/1ps
`include "pms_params.svh"

module tb_top;
  import pms_pkg::*;
  localparam int DEB = 4;
  localparam int DSP = 8;
  logic aclk, aresetn;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] wdata, rdata, rd;
  logic [15:0] par_in;
  logic [1023:0] prog_map;
  logic hold_on, lkp_programmed, disp_req, notice_req;
  logic [2:0] bank;
  pms_ctl_s ctl_in;
  pms_msg_t lkp_num, last_num;
  pms_disp_s disp;
  pms_msg_t exp_q[$];
  int n_fail, checks, cyc, n_notice, k, j, m, n;
  logic rr_mode;

  pms_selector #(.NUM_IN(16), .DEB_CYC_DEF(32'(DEB)),
    .DISP_CYC_DEF(32'(DSP))) i_pms_selector (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .par_in(par_in), .ctl_in(ctl_in), .lkp_num(lkp_num),
    .lkp_programmed(lkp_programmed), .disp_req(disp_req),
    .disp(disp), .notice_req(notice_req));

  pms_field i_pms_field (.prog_map(prog_map), .lkp_num(lkp_num),
    .lkp_programmed(lkp_programmed), .hold_on(hold_on),
    .bank(bank), .ctl_in(ctl_in));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic fail(input string s);
    n_fail = n_fail + 1;
    $display("ERROR %0t %s", $time, s);
  endtask : fail

  task automatic cmp_msg(input pms_msg_t e, input pms_msg_t g);
    checks = checks + 1;
    if (g !== e) fail($sformatf("shown %0d, wanted %0d", g, e));
  endtask : cmp_msg

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    checks = checks + 1;
    if (g !== e) fail($sformatf("read %h, wanted %h", g, e));
  endtask : cmp_word

  // Every noted message must have appeared by now
  task automatic check_q;
    checks = checks + 1;
    if (exp_q.size() != 0) fail("message missing");
    exp_q.delete();
  endtask : check_q

  task automatic wt(input int c);
    repeat (c) @(posedge aclk);
  endtask : wt

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    cmp_word(32'(`PMS_RESP_OKAY), 32'(bresp));
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    cmp_word(32'(`PMS_RESP_OKAY), 32'(rresp));
    rready <= 1'b0;
  endtask : rdr

  // Hang guard
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      fail("timeout");
      wrap_up();
    end
  end

  // A change of the shown message is one result
  always @(posedge aclk) begin
    if (aresetn && notice_req === 1'b1) n_notice = n_notice + 1;
    if (aresetn && disp_req === 1'b1 && disp.num !== last_num) begin
      last_num = disp.num;
      if (exp_q.size() == 0) fail("unexpected message");
      else cmp_msg(exp_q.pop_front(), disp.num);
      cmp_word(32'(rr_mode), 32'(disp.first));
    end
  end

  initial begin
    cyc = 0;
    n_fail = 0;
    checks = 0;
    n_notice = 0;
    last_num = '0;
    rr_mode = 1'b1;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    par_in = '0;
    prog_map = '0;
    hold_on = 1'b0;
    bank = 3'h0;
    void'($urandom(32'h5051));
    wt(12);
    aresetn <= 1'b1;
    rdr(`PMS_ADDR_CTRL, rd);
    cmp_word(`PMS_CTRL_RESET, rd);
    rdr(`PMS_ADDR_DEBOUNCE, rd);
    cmp_word(32'(DEB), rd);
    rdr(`PMS_ADDR_DISPLAY, rd);
    cmp_word(32'(DSP), rd);
    wr(`PMS_ADDR_STATUS, 32'hFFFF_FFFF);
    rdr(`PMS_ADDR_CTRL, rd);
    cmp_word(`PMS_CTRL_RESET, rd);
    // Round robin, bank 5
    k = $urandom_range(15, 0);
    j = (k + 3) % 16;
    m = (k + 7) % 16;
    n = (k + 11) % 16;
    bank <= 3'h5;
    hold_on <= 1'b1;
    prog_map[501 + k] <= 1'b1;
    wt(100);
    exp_q.push_back(10'(501 + k));
    par_in[k] <= 1'b1;
    wt(300);
    check_q();
    par_in[k] <= 1'b0;
    wt(100);
    // Bank 3: short glitch, then an OFF message
    bank <= 3'h3;
    prog_map[301 + j] <= 1'b1;
    prog_map[317 + m] <= 1'b1;
    wt(100);
    par_in[j] <= 1'b1;
    @(posedge aclk);
    par_in[j] <= 1'b0;
    par_in[m] <= 1'b1;
    wt(200);
    check_q();
    exp_q.push_back(10'(317 + m));
    par_in[m] <= 1'b0;
    wt(200);
    check_q();
    prog_map[317 + m] <= 1'b0;
    // Strobe line gates display
    hold_on <= 1'b0;
    prog_map[301 + n] <= 1'b1;
    wt(100);
    par_in[n] <= 1'b1;
    wt(200);
    par_in[n] <= 1'b0;
    wt(100);
    hold_on <= 1'b1;
    wt(100);
    exp_q.push_back(10'(301 + n));
    par_in[n] <= 1'b1;
    wt(200);
    check_q();
    par_in[n] <= 1'b0;
    wt(100);
    // Priority operation
    bank <= 3'h0;
    prog_map[`PMS_DEFAULT_MSG] <= 1'b1;
    prog_map[10'h003] <= 1'b1;
    prog_map[10'h007] <= 1'b1;
    wt(100);
    exp_q.push_back(`PMS_DEFAULT_MSG);
    rr_mode = 1'b0;
    wr(`PMS_ADDR_CTRL, 32'h0000_0001);
    wt(100);
    exp_q.push_back(10'h007);
    par_in[6] <= 1'b1;
    wt(100);
    exp_q.push_back(10'h003);
    par_in[2] <= 1'b1;
    wt(100);
    exp_q.push_back(10'h007);
    par_in[2] <= 1'b0;
    wt(100);
    prog_map[`PMS_DEFAULT_MSG] <= 1'b0;
    par_in[6] <= 1'b0;
    wt(100);
    check_q();
    cmp_word(32'h0000_0001, 32'(n_notice > 0));
    // Twenty input round robin, strobe low
    hold_on <= 1'b0;
    wt(50);
    rr_mode = 1'b1;
    wr(`PMS_ADDR_CTRL, 32'h0000_0002);
    prog_map[`PMS_DEFAULT_MSG] <= 1'b1;
    wt(100);
    exp_q.push_back(`PMS_DEFAULT_MSG);
    bank <= 3'h1;
    wt(200);
    check_q();
    bank <= 3'h0;
    prog_map[10'h014] <= 1'b1;
    wt(100);
    exp_q.push_back(10'h014);
    hold_on <= 1'b1;
    wt(200);
    check_q();
    wrap_up();
  end
endmodule : tb_top
